// ### core/rmc_pkg.sv
// Purpose: Shared constants for the reference monitor register bank.
// Assumes: 250 MHz system clock, byte-wide serial register port.
// Notes:   Timing counts derive from printed times; top may override them.
package rmc_pkg;

   localparam int NUM_REFS = 4;

   // Register offsets
   localparam logic [7:0] ADDR_ISR_STATUS  = 8'h02;
   localparam logic [7:0] ADDR_MON_FAIL_23 = 8'h06;
   localparam logic [7:0] ADDR_MON_FAIL_01 = 8'h07;
   localparam logic [7:0] ADDR_MASK_23     = 8'h08;
   localparam logic [7:0] ADDR_MASK_01     = 8'h09;
   localparam logic [7:0] ADDR_INPUT_CFG   = 8'h0a;
   localparam logic [7:0] ADDR_DISQ_SEL    = 8'h0b;
   localparam logic [7:0] ADDR_QUAL_SEL    = 8'h0c;
   localparam logic [7:0] ADDR_LOCK        = 8'h0d;
   localparam logic [7:0] ADDR_BASE_HI     = 8'h10;
   localparam logic [7:0] ADDR_BASE_LO     = 8'h11;
   localparam logic [7:0] ADDR_MULT_HI     = 8'h12;
   localparam logic [7:0] ADDR_MULT_LO     = 8'h13;

   // Reset values
   localparam logic [7:0]  RST_MON_FAIL   = 8'h00;
   localparam logic [7:0]  RST_MASK       = 8'h66;
   localparam logic [7:0]  RST_INPUT_CFG  = 8'h10;
   localparam logic [7:0]  RST_DISQ_SEL   = 8'haa;
   localparam logic [7:0]  RST_QUAL_SEL   = 8'h55;
   localparam logic [7:0]  RST_LOCK       = 8'h00;
   localparam logic [15:0] RST_BASE_RATE  = 16'h9c40;
   localparam logic [15:0] RST_RATE_MULT  = 16'h0f30;

   // Lock register codes
   localparam logic [7:0] LOCK_ON  = 8'h01;
   localparam logic [7:0] LOCK_OFF = 8'h00;

   // Field positions inside one reference nibble; FLD_DIFF_BASE is the differential select base in the input config byte
   localparam int FLD_SIGNAL_ABSENT = 0;
   localparam int FLD_SINGLE_PERIOD = 1;
   localparam int FLD_ROUGH_RATE    = 2;
   localparam int FLD_SOAK_EXPIRED  = 3;
   localparam int FLD_DIFF_BASE     = 4;

   // Supported base rate span, hertz
   localparam logic [15:0] BASE_RATE_MIN = 16'h03e8;
   localparam logic [15:0] BASE_RATE_MAX = 16'h9c40;

   // Soak timer times in microseconds and cycle counts at the clock rate
   localparam longint CLK_HZ      = 250_000_000;
   localparam longint T_DISQ1_US  = 10_000;
   localparam longint T_DISQ2_US  = 50_000;
   localparam longint T_DISQ3_US  = 2_500_000;
   localparam int unsigned DISQ1_CYC = 32'(T_DISQ1_US * CLK_HZ / 1_000_000);
   localparam int unsigned DISQ2_CYC = 32'(T_DISQ2_US * CLK_HZ / 1_000_000);
   localparam int unsigned DISQ3_CYC = 32'(T_DISQ3_US * CLK_HZ / 1_000_000);
   localparam int unsigned DISQ0_CYC = 32'd1;

   typedef enum logic [1:0] {
      DISQ_MIN, DISQ_SHORT, DISQ_MID, DISQ_LONG
   } rmc_disq_type;

endpackage

// ### core/rmc_ref_input.sv
// Purpose: One reference input path: pin sync, input type, halving.
// Assumes: Reference pins are asynchronous to CLK and slower than CLK/4.
// Notes:   Output is a sampled version, good for monitoring only.
`timescale 1ns/1ns
module rmc_ref_input
   import rmc_pkg::*;
(
   input  wire logic clk,
   input  wire logic rst,
   input  wire logic pos_pin,
   input  wire logic neg_pin,
   input  wire logic differential_select,
   input  wire logic halve_enable,
   output logic      ref_out
);

   logic [1:0] pos_sync_q;
   logic [1:0] neg_sync_q;
   logic       level_q;
   logic       half_q;
   logic       level_d;

   ////////////////////////////////////////////////////////////////////////
   // Two-stage synchronisers on both pins
   always_ff @(posedge clk) begin
      if (rst) begin
         pos_sync_q <= 2'h0;
         neg_sync_q <= 2'h0;
      end else begin
         pos_sync_q <= {pos_sync_q[0], pos_pin};
         neg_sync_q <= {neg_sync_q[0], neg_pin};
      end
   end

   // Differential compares both legs, otherwise positive leg only
   assign level_d = differential_select ? (pos_sync_q[1] & ~neg_sync_q[1])
                                        : pos_sync_q[1];

   ////////////////////////////////////////////////////////////////////////
   // Halving toggles on each rising edge of the selected level
   always_ff @(posedge clk) begin
      if (rst) begin
         level_q <= 1'b0;
         half_q  <= 1'b0;
         ref_out <= 1'b0;
      end else begin
         level_q <= level_d;
         if (level_d && !level_q) begin
            half_q <= ~half_q;
         end
         ref_out <= halve_enable ? half_q : level_q;
      end
   end

endmodule

// ### core/rmc_soak_timer.sv
// Purpose: Guard soak timer for one reference.
// Assumes: Failure inputs are on CLK.
// Notes:   Expiry is a one-cycle pulse on disqualification.
`timescale 1ns/1ns
module rmc_soak_timer
   import rmc_pkg::*;
#(
   parameter int unsigned DISQ1 = DISQ1_CYC,
   parameter int unsigned DISQ2 = DISQ2_CYC,
   parameter int unsigned DISQ3 = DISQ3_CYC
)(
   input  wire logic       clk,
   input  wire logic       rst,
   input  wire logic       fail,
   input  wire logic [1:0] disqualify_time,
   input  wire logic [1:0] qualify_time,
   output logic            qualified,
   output logic            expired
);

   typedef enum logic [1:0] {S_GOOD, S_DISQ_WAIT, S_BAD, S_QUAL_WAIT} rmc_soak_type;

   rmc_soak_type state_q;
   logic [32:0]  cnt_q;
   logic [32:0]  disq_lim;
   logic [32:0]  qual_lim;

   ////////////////////////////////////////////////////////////////////////
   // Disqualify time from its select, requalify as an even multiple
   always_comb begin
      unique case (rmc_disq_type'(disqualify_time))
         DISQ_MIN:   disq_lim = 33'(DISQ0_CYC);
         DISQ_SHORT: disq_lim = 33'(DISQ1);
         DISQ_MID:   disq_lim = 33'(DISQ2);
         DISQ_LONG:  disq_lim = 33'(DISQ3);
      endcase
      // 2x, 4x, 6x, 8x; 33 bits hold 8 x 2.5 s
      qual_lim = 33'(disq_lim * 33'({1'b0, qualify_time, 1'b0} + 4'h2));
   end

   ////////////////////////////////////////////////////////////////////////
   // Soak state machine
   always_ff @(posedge clk) begin
      if (rst) begin
         state_q   <= S_GOOD;
         cnt_q     <= 33'h0;
         qualified <= 1'b1;
         expired   <= 1'b0;
      end else begin
         expired <= 1'b0;
         cnt_q   <= cnt_q + 33'h1;
         unique case (state_q)
            S_GOOD: begin
               cnt_q <= 33'h0;
               if (fail) begin
                  state_q <= S_DISQ_WAIT;
               end
            end
            S_DISQ_WAIT: begin
               if (!fail) begin
                  state_q <= S_GOOD;
               end else if (cnt_q >= disq_lim - 33'h1) begin
                  state_q   <= S_BAD;
                  qualified <= 1'b0;
                  expired   <= 1'b1;
                  cnt_q     <= 33'h0;
               end
            end
            S_BAD: begin
               cnt_q <= 33'h0;
               if (!fail) begin
                  state_q <= S_QUAL_WAIT;
               end
            end
            S_QUAL_WAIT: begin
               if (fail) begin
                  state_q <= S_BAD;
               end else if (cnt_q >= qual_lim - 33'h1) begin
                  state_q   <= S_GOOD;
                  qualified <= 1'b1;
               end
            end
         endcase
      end
   end

endmodule

// ### core/rmc_ref_monitor_regs.sv
// Purpose: Register bank for four reference monitors and their status.
// Assumes: Serial port logic delivers one-cycle byte read/write strobes.
// Notes:   Status reads clear the bits they return; lock freezes setting.
//
// What this block does
// - Signal-absent input sets nibble bit 0
// - Single-period failure sets nibble bit 1
// - Rough-rate failure sets nibble bit 2
// - Soak timer expiry sets nibble bit 3
// - Monitor flags update regardless of masks
// - Refs 0/1 at 0x07, 2/3 at 0x06
// - Per-reference four-bit enable mask, one enables
// - Mask gates only interrupt status at 0x02
// - Halve enable divides reference input by two
// - Select bit chooses differential or single-ended
// - Disqualify after selected soak time
// - Requalify after 2/4/6/8 times disqualify
// - Lock value 0x01 stops latched status from setting; reads still clear it
// - Base rate is unsigned hertz value
// - Wide registers big-endian, MSB lower address
// - Unmasked interrupt status drives interrupt request
`timescale 1ns/1ns
module rmc_ref_monitor_regs
   import rmc_pkg::*;
#(
   parameter int unsigned DISQ1 = DISQ1_CYC,
   parameter int unsigned DISQ2 = DISQ2_CYC,
   parameter int unsigned DISQ3 = DISQ3_CYC
)(
   input  wire logic                CLK,
   input  wire logic                RST,
   input  wire logic                REG_WR,
   input  wire logic                REG_RD,
   input  wire logic [7:0]          REG_ADDR,
   input  wire logic [7:0]          REG_WDATA,
   output logic      [7:0]          REG_RDATA,
   output logic                     REG_RVALID,
   input  wire logic [NUM_REFS-1:0] IN_POS_PIN,
   input  wire logic [NUM_REFS-1:0] IN_NEG_PIN,
   input  wire logic [NUM_REFS-1:0] SIGNAL_ABSENT_PIN,
   input  wire logic [NUM_REFS-1:0] SINGLE_PERIOD_FAIL,
   input  wire logic [NUM_REFS-1:0] ROUGH_RATE_FAIL,
   output logic      [NUM_REFS-1:0] REF_CLK_OUT,
   output logic      [NUM_REFS-1:0] REF_QUALIFIED,
   output logic      [15:0]         BASE_RATE,
   output logic      [15:0]         RATE_MULTIPLIER,
   output logic                     IRQ
);

   logic [15:0]         mon_flags_q;   // Ref n in bits 4n+3:4n
   logic [15:0]         mask_q;
   logic [3:0]          isr_q;
   logic [7:0]          input_cfg_q;
   logic [7:0]          disq_sel_q;
   logic [7:0]          qual_sel_q;
   logic [7:0]          lock_q;
   logic [NUM_REFS-1:0] absent_s1_q;
   logic [NUM_REFS-1:0] absent_s2_q;
   logic [NUM_REFS-1:0] soak_expired;
   logic [15:0]         mon_events;
   logic [3:0]          isr_events;
   logic [15:0]         mon_clr;
   logic [3:0]          isr_clr;
   logic                locked;
   logic [7:0]          rdata_d;

   assign locked = (lock_q == LOCK_ON);

   ////////////////////////////////////////////////////////////////////////
   // Signal-absent pins come from outside, so two flops first
   always_ff @(posedge CLK) begin
      if (RST) begin
         absent_s1_q <= '0;
         absent_s2_q <= '0;
      end else begin
         absent_s1_q <= SIGNAL_ABSENT_PIN;
         absent_s2_q <= absent_s1_q;
      end
   end

   ////////////////////////////////////////////////////////////////////////
   // Per-reference input path, soak timer and event gathering
   for (genvar r = 0; r < NUM_REFS; r++) begin : g_ref
      rmc_ref_input u_input (
         .clk                 (CLK),
         .rst                 (RST),
         .pos_pin             (IN_POS_PIN[r]),
         .neg_pin             (IN_NEG_PIN[r]),
         .differential_select (input_cfg_q[FLD_DIFF_BASE + r]),
         .halve_enable        (input_cfg_q[r]),
         .ref_out             (REF_CLK_OUT[r])
      );

      rmc_soak_timer #(
         .DISQ1 (DISQ1),
         .DISQ2 (DISQ2),
         .DISQ3 (DISQ3)
      ) u_soak (
         .clk             (CLK),
         .rst             (RST),
         .fail            (SINGLE_PERIOD_FAIL[r] | ROUGH_RATE_FAIL[r]),
         .disqualify_time (disq_sel_q[2*r +: 2]),
         .qualify_time    (qual_sel_q[2*r +: 2]),
         .qualified       (REF_QUALIFIED[r]),
         .expired         (soak_expired[r])
      );

      // Raw monitor events, never masked
      assign mon_events[4*r + FLD_SIGNAL_ABSENT] = absent_s2_q[r];
      assign mon_events[4*r + FLD_SINGLE_PERIOD] = SINGLE_PERIOD_FAIL[r];
      assign mon_events[4*r + FLD_ROUGH_RATE]    = ROUGH_RATE_FAIL[r];
      assign mon_events[4*r + FLD_SOAK_EXPIRED]  = soak_expired[r];

      // Only the interrupt status sees the enable mask
      assign isr_events[r] = |(mon_events[4*r +: 4] & mask_q[4*r +: 4]);
   end

   ////////////////////////////////////////////////////////////////////////
   // Read clears only the bits it returned, so a same-cycle event survives
   always_comb begin
      mon_clr = '0;
      isr_clr = '0;
      if (REG_RD) begin
         unique case (REG_ADDR)
            ADDR_ISR_STATUS:  isr_clr         = isr_q;
            ADDR_MON_FAIL_23: mon_clr[15:8]   = mon_flags_q[15:8];
            ADDR_MON_FAIL_01: mon_clr[7:0]    = mon_flags_q[7:0];
            default:          mon_clr         = '0;
         endcase
      end
   end

   ////////////////////////////////////////////////////////////////////////
   // Latched status: set wins over clear, lock stops setting
   always_ff @(posedge CLK) begin
      if (RST) begin
         mon_flags_q <= {RST_MON_FAIL, RST_MON_FAIL};
         isr_q       <= 4'h0;
      end else begin
         // Flags hold until read, whatever the source does later
         mon_flags_q <= (mon_flags_q & ~mon_clr)
                      | (locked ? 16'h0000 : mon_events);
         isr_q       <= (isr_q & ~isr_clr)
                      | (locked ? 4'h0 : isr_events);
      end
   end

   ////////////////////////////////////////////////////////////////////////
   // Interrupt request follows unmasked status in the same cycle, one cycle after the event
   always_ff @(posedge CLK) begin
      if (RST) begin
         IRQ <= 1'b0;
      end else begin
         IRQ <= |(isr_q & ~isr_clr) | (!locked && |isr_events);
      end
   end

   ////////////////////////////////////////////////////////////////////////
   // Writable configuration; wide values land byte by byte, big-endian
   always_ff @(posedge CLK) begin
      if (RST) begin
         mask_q          <= {RST_MASK, RST_MASK};
         input_cfg_q     <= RST_INPUT_CFG;
         disq_sel_q      <= RST_DISQ_SEL;
         qual_sel_q      <= RST_QUAL_SEL;
         lock_q          <= RST_LOCK;
         BASE_RATE       <= RST_BASE_RATE;
         RATE_MULTIPLIER <= RST_RATE_MULT;
      end else if (REG_WR) begin
         unique case (REG_ADDR)
            ADDR_MASK_23:   mask_q[15:8]          <= REG_WDATA;
            ADDR_MASK_01:   mask_q[7:0]           <= REG_WDATA;
            ADDR_INPUT_CFG: input_cfg_q           <= REG_WDATA;
            ADDR_DISQ_SEL:  disq_sel_q            <= REG_WDATA;
            ADDR_QUAL_SEL:  qual_sel_q            <= REG_WDATA;
            ADDR_LOCK:      lock_q                <= REG_WDATA;
            // Unsigned hertz, no range check: out-of-span values just store
            ADDR_BASE_HI:   BASE_RATE[15:8]       <= REG_WDATA;
            ADDR_BASE_LO:   BASE_RATE[7:0]        <= REG_WDATA;
            ADDR_MULT_HI:   RATE_MULTIPLIER[15:8] <= REG_WDATA;
            ADDR_MULT_LO:   RATE_MULTIPLIER[7:0]  <= REG_WDATA;
            default:        lock_q                <= lock_q;
         endcase
      end
   end

   ////////////////////////////////////////////////////////////////////////
   // Read mux; unmapped addresses return zero
   always_comb begin
      unique case (REG_ADDR)
         ADDR_ISR_STATUS:  rdata_d = {4'h0, isr_q};
         ADDR_MON_FAIL_23: rdata_d = mon_flags_q[15:8];
         ADDR_MON_FAIL_01: rdata_d = mon_flags_q[7:0];
         ADDR_MASK_23:     rdata_d = mask_q[15:8];
         ADDR_MASK_01:     rdata_d = mask_q[7:0];
         ADDR_INPUT_CFG:   rdata_d = input_cfg_q;
         ADDR_DISQ_SEL:    rdata_d = disq_sel_q;
         ADDR_QUAL_SEL:    rdata_d = qual_sel_q;
         ADDR_LOCK:        rdata_d = lock_q;
         ADDR_BASE_HI:     rdata_d = BASE_RATE[15:8];
         ADDR_BASE_LO:     rdata_d = BASE_RATE[7:0];
         ADDR_MULT_HI:     rdata_d = RATE_MULTIPLIER[15:8];
         ADDR_MULT_LO:     rdata_d = RATE_MULTIPLIER[7:0];
         default:          rdata_d = 8'h00;
      endcase
   end

   // Registered read answer, one cycle after the strobe
   always_ff @(posedge CLK) begin
      if (RST) begin
         REG_RDATA  <= 8'h00;
         REG_RVALID <= 1'b0;
      end else begin
         REG_RVALID <= REG_RD;
         if (REG_RD) begin
            REG_RDATA <= rdata_d;
         end
      end
   end

endmodule

// ### dv/rmc_regs_sva.sv
// Purpose: Port-level assertions for the reference monitor register bank.
// Assumes: Default register values; lock and selects tracked from writes.
// Notes:   Mirrors only the few control bytes the properties depend on.
`timescale 1ns/1ns
module rmc_regs_sva
   import rmc_pkg::*;
(
   input wire logic                CLK,
   input wire logic                RST,
   input wire logic                REG_WR,
   input wire logic                REG_RD,
   input wire logic [7:0]          REG_ADDR,
   input wire logic [7:0]          REG_WDATA,
   input wire logic [7:0]          REG_RDATA,
   input wire logic [NUM_REFS-1:0] SINGLE_PERIOD_FAIL,
   input wire logic [NUM_REFS-1:0] ROUGH_RATE_FAIL,
   input wire logic [NUM_REFS-1:0] REF_QUALIFIED,
   input wire logic [15:0]         BASE_RATE,
   input wire logic [15:0]         RATE_MULTIPLIER,
   input wire logic                IRQ
);
   logic       lk_q;
   logic [7:0] mask_q;
   logic [7:0] disq_q;
   logic [7:0] qual_q;
   logic [7:0] pend_q;
   logic       rd07;
   logic       f0;
   logic [7:0] set_now;
   // Events the flag byte at 0x07 must have caught
   assign rd07    = REG_RD && REG_ADDR == ADDR_MON_FAIL_01;
   assign f0      = SINGLE_PERIOD_FAIL[0] | ROUGH_RATE_FAIL[0];
   assign set_now = lk_q ? 8'h00 : {2'h0, SINGLE_PERIOD_FAIL[1], 2'h0, ROUGH_RATE_FAIL[0], 2'h0};
   // Shadow of the control bytes the properties need
   always_ff @(posedge CLK) begin
      if (RST) begin
         lk_q   <= 1'b0;
         mask_q <= 8'h66;
         disq_q <= 8'haa;
         qual_q <= 8'h55;
      end else if (REG_WR) begin
         case (REG_ADDR)
            ADDR_MASK_01:  mask_q <= REG_WDATA;
            ADDR_DISQ_SEL: disq_q <= REG_WDATA;
            ADDR_QUAL_SEL: qual_q <= REG_WDATA;
            ADDR_LOCK:     lk_q <= REG_WDATA == LOCK_ON;
            default:       ;
         endcase
      end
   end
   // Pending flags; a set in the read cycle survives, as the design does
   always_ff @(posedge CLK) begin
      if (RST) begin
         pend_q <= 8'h00;
      end else if (rd07) begin
         pend_q <= set_now;
      end else begin
         pend_q <= pend_q | set_now;
      end
   end
   ////////////////////////////////////////////////////////////////
   default clocking @(posedge CLK); endclocking
   default disable iff (RST);
   sequence s_lock_rd;
      lk_q && rd07;
   endsequence
   sequence s_good;
      (disq_q[1:0] == 2'd0 && qual_q[1:0] == 2'd3 && !f0)[*8];
   endsequence
   property p_rough_flag;
      rd07 && pend_q[2] |=> REG_RDATA[2];
   endproperty
   property p_single_flag;
      rd07 && pend_q[5] |=> REG_RDATA[5];
   endproperty
   property p_irq;
      ROUGH_RATE_FAIL[0] && mask_q[2] && !lk_q |=> IRQ;
   endproperty
   property p_disq;
      disq_q[1:0] == 2'd0 && f0 ##1 f0 |=> !REF_QUALIFIED[0];
   endproperty
   property p_requal;
      s_good ##1 s_good |-> REF_QUALIFIED[0];
   endproperty
   property p_base_hi;
      REG_WR && REG_ADDR == ADDR_BASE_HI |=> BASE_RATE[15:8] == $past(REG_WDATA);
   endproperty
   property p_mult_lo;
      REG_WR && REG_ADDR == ADDR_MULT_LO |=> RATE_MULTIPLIER[7:0] == $past(REG_WDATA);
   endproperty
   property p_lock;
      s_lock_rd ##2 s_lock_rd |=> REG_RDATA == 8'h00;
   endproperty
   a_rough_flag: assert property (p_rough_flag)
      else $error("rough-rate flag missing on read");
   a_single_flag: assert property (p_single_flag)
      else $error("single-period flag missing on read");
   a_irq: assert property (p_irq)
      else $error("enabled failure gave no interrupt");
   a_disq: assert property (p_disq)
      else $error("minimum disqualify too slow");
   a_requal: assert property (p_requal)
      else $error("requalify overdue");
   a_base_hi: assert property (p_base_hi)
      else $error("base rate high byte not stored");
   a_mult_lo: assert property (p_mult_lo)
      else $error("multiplier low byte not stored");
   a_lock: assert property (p_lock)
      else $error("flags updated while locked");
endmodule

bind rmc_ref_monitor_regs rmc_regs_sva u_sva (
   .CLK(CLK), .RST(RST), .REG_WR(REG_WR), .REG_RD(REG_RD), .REG_ADDR(REG_ADDR),
   .REG_WDATA(REG_WDATA), .REG_RDATA(REG_RDATA), .SINGLE_PERIOD_FAIL(SINGLE_PERIOD_FAIL),
   .ROUGH_RATE_FAIL(ROUGH_RATE_FAIL), .REF_QUALIFIED(REF_QUALIFIED), .BASE_RATE(BASE_RATE),
   .RATE_MULTIPLIER(RATE_MULTIPLIER), .IRQ(IRQ)
);

// ### dv/rmc_host_model.sv
// Purpose: Host side of the byte register port.
// Assumes: Strobes rise 1 ns after an edge and are taken at the next edge.
// Notes:   Released address and data flip so stale values never match.
`timescale 1ns/1ns
module rmc_host_model (
   input  wire logic       clk,
   output logic            reg_wr,
   output logic            reg_rd,
   output logic [7:0]      reg_addr,
   output logic [7:0]      reg_wdata,
   input  wire logic [7:0] reg_rdata,
   input  wire logic       reg_rvalid
);
   // Idle bus at time zero
   initial begin
      reg_wr = 1'b0;
      reg_rd = 1'b0;
      reg_addr = 8'h00;
      reg_wdata = 8'h00;
   end
   // One byte write, held across the taking edge
   task automatic wr(input logic [7:0] a, input logic [7:0] d);
      @(posedge clk);
      #1;
      reg_wr = 1'b1;
      reg_addr = a;
      reg_wdata = d;
      @(posedge clk);
      #1;
      reg_wr = 1'b0;
      reg_addr = ~a;
      reg_wdata = ~d;
   endtask
   // Wide values go most significant byte first, at the lower address
   task automatic wr16(input logic [7:0] a, input logic [15:0] d);
      wr(a, d[15:8]);
      wr(a + 8'h01, d[7:0]);
   endtask
   // Read; a missing answer yields unknown data, which never matches
   task automatic rd(input logic [7:0] a, output logic [7:0] d);
      @(posedge clk);
      #1;
      reg_rd = 1'b1;
      reg_addr = a;
      @(posedge clk);
      #1;
      reg_rd = 1'b0;
      reg_addr = ~a;
      d = reg_rvalid ? reg_rdata : 8'hxx;
   endtask
endmodule

// ### dv/rmc_ref_monitor_regs_tb_top.sv
// Purpose: Directed tests of the reference monitor register bank.
// Assumes: Short soak counts 5/10/20 cycles; inputs move 1 ns after edges.
// Notes:   Expected values come from the register map, not the design.
`timescale 1ns/1ns
module rmc_ref_monitor_regs_tb_top
   import rmc_pkg::*;
;
   logic       clk;
   logic       rst;
   logic       reg_wr;
   logic       reg_rd;
   logic [7:0] reg_addr;
   logic [7:0] reg_wdata;
   logic [7:0] reg_rdata;
   logic       reg_rvalid;
   logic [3:0] in_pos;
   logic [3:0] in_neg;
   logic [3:0] absent;
   logic [3:0] single;
   logic [3:0] rough;
   logic [3:0] ref_out;
   logic [3:0] qual;
   logic [15:0] base_rate;
   logic [15:0] rate_mult;
   logic       irq;
   logic [7:0] a;
   logic [1:0] prev;
   int         failures;
   int         tests_run;
   int         r;
   int         k;
   int         cnt2;
   int         cnt3;
   logic [7:0] rstv [6] = '{8'h66, 8'h66, 8'h10, 8'haa, 8'h55, 8'h00};
   rmc_ref_monitor_regs #(.DISQ1(5), .DISQ2(10), .DISQ3(20)) dut (
      .CLK(clk), .RST(rst), .REG_WR(reg_wr), .REG_RD(reg_rd), .REG_ADDR(reg_addr),
      .REG_WDATA(reg_wdata), .REG_RDATA(reg_rdata), .REG_RVALID(reg_rvalid),
      .IN_POS_PIN(in_pos), .IN_NEG_PIN(in_neg), .SIGNAL_ABSENT_PIN(absent),
      .SINGLE_PERIOD_FAIL(single), .ROUGH_RATE_FAIL(rough), .REF_CLK_OUT(ref_out),
      .REF_QUALIFIED(qual), .BASE_RATE(base_rate), .RATE_MULTIPLIER(rate_mult), .IRQ(irq)
   );
   rmc_host_model host (
      .clk(clk), .reg_wr(reg_wr), .reg_rd(reg_rd), .reg_addr(reg_addr),
      .reg_wdata(reg_wdata), .reg_rdata(reg_rdata), .reg_rvalid(reg_rvalid)
   );
   ////////////////////////////////////////////////////////////////
   // 250 MHz clock
   always #2 clk = ~clk;
   // Compare and count
   task automatic chk(input logic [15:0] seen, input logic [15:0] exp);
      tests_run++;
      if (seen !== exp) begin
         failures++;
         $display("BAD t=%0t got %h want %h", $time, seen, exp);
      end
   endtask
   task automatic rdc(input logic [7:0] ad, input logic [7:0] e);
      logic [7:0] d;
      host.rd(ad, d);
      chk(16'(d), 16'(e));
   endtask
   task automatic cyc(input int n);
      repeat (n) @(posedge clk);
      #1;
   endtask
   // Drive one failure input: 0 absent, 1 single-period, 2 rough-rate
   task automatic setin(input int kd, input int rf, input logic v);
      case (kd)
         0: absent[rf] = v;
         1: single[rf] = v;
         default: rough[rf] = v;
      endcase
   endtask
   task automatic end_sim();
      $display("Compares %0d, mismatches %0d", tests_run, failures);
      if (failures == 0 && tests_run > 0) begin
         $display("*** PASS ***");
      end else begin
         $display("*** FAIL ***");
      end
      $finish;
   endtask
   // Hang guard, far beyond the few hundred cycles the tests need
   initial begin
      #40000;
      failures++;
      $display("BAD t=%0t watchdog expired", $time);
      end_sim();
   end
   ////////////////////////////////////////////////////////////////
   initial begin
      {clk, in_pos, in_neg, absent, single, rough} = '0;
      rst = 1'b1;
      failures = 0;
      tests_run = 0;
      repeat (12) @(posedge clk);
      #1;
      rst = 1'b0;
      for (int i = 0; i < 6; i++) rdc(8'h08 + 8'(i), rstv[i]);
      rdc(8'h06, 8'h00);
      rdc(8'h0e, 8'h00);
      chk(base_rate, 16'h9c40);
      chk(rate_mult, 16'h0f30);
      $display("Test reset done");
      // Byte order of wide fields; read-only status refuses writes
      host.wr16(8'h10, 16'h03e8);
      host.wr16(8'h12, 16'h0008); // Eight times 1 kHz
      chk(base_rate, 16'h03e8);
      chk(rate_mult, 16'h0008);
      host.wr(8'h10, 8'h9c);
      chk(base_rate, 16'h9ce8);
      host.wr(8'h07, 8'hff);
      rdc(8'h07, 8'h00);
      $display("Test wide done");
      // Each failure input on every reference, sticky after the cause ends
      for (r = 0; r < 4; r++) begin
         for (k = 0; k < 3; k++) begin
            setin(k, r, 1'b1);
            cyc(3);
            setin(k, r, 1'b0);
            cyc(4);
            a = (r < 2) ? 8'h07 : 8'h06;
            chk(16'(irq), 16'(k != 0));
            rdc(a, 8'h01 << (k + 4 * (r % 2)));
            rdc(a, 8'h00);
            rdc(8'h02, (k != 0) ? 8'h01 << r : 8'h00);
            cyc(2);
            chk(16'(irq), 16'h0000);
         end
      end
      $display("Test flags done");
      // Masks gate only the summary byte
      host.wr(8'h09, 8'h01);
      host.wr(8'h08, 8'h00);
      rough = 4'hf;
      cyc(2);
      rough = 4'h0;
      cyc(2);
      rdc(8'h07, 8'h44);
      rdc(8'h06, 8'h44);
      rdc(8'h02, 8'h00);
      absent[0] = 1'b1;
      cyc(3);
      absent[0] = 1'b0;
      cyc(4);
      rdc(8'h02, 8'h01);
      rdc(8'h07, 8'h01);
      $display("Test mask done");
      // Soak timer: ref0 minimum delay and 8x, ref1 short delay and 2x
      host.wr(8'h0b, 8'h04);
      host.wr(8'h0c, 8'h03);
      rough[1:0] = 2'b11;
      cyc(3);
      chk(16'(qual[1:0]), 16'h0002);
      cyc(6);
      chk(16'(qual[1:0]), 16'h0000);
      rough[1:0] = 2'b00;
      cyc(4);
      chk(16'(qual[0]), 16'h0000);
      cyc(8);
      chk(16'(qual[0]), 16'h0001);
      cyc(8);
      chk(16'(qual[1:0]), 16'h0003);
      rdc(8'h07, 8'hcc);
      host.wr(8'h0b, 8'haa);
      $display("Test soak done");
      // Lock freezes setting; unlock resumes it
      host.wr(8'h0d, 8'h01);
      rough[0] = 1'b1;
      cyc(2);
      rdc(8'h07, 8'h00);
      rdc(8'h07, 8'h00);
      rough[0] = 1'b0;
      host.wr(8'h0d, 8'h00);
      rough[0] = 1'b1;
      cyc(2);
      rough[0] = 1'b0;
      rdc(8'h07, 8'h04);
      $display("Test lock done");
      // Input type and halving; rate multiplier set for the halved input
      host.wr(8'h0a, 8'h14);
      host.wr16(8'h12, 16'h0004);
      in_pos = 4'b0011;
      in_neg = 4'b0011;
      cyc(6);
      chk(16'(ref_out[1:0]), 16'h0002);
      in_neg = 4'b0000;
      cyc(6);
      chk(16'(ref_out[1:0]), 16'h0003);
      prev = ref_out[3:2];
      cnt2 = 0;
      cnt3 = 0;
      for (int i = 0; i < 128; i++) begin
         if (i % 8 == 0) in_pos[3:2] = ~in_pos[3:2];
         cyc(1);
         if (ref_out[2] === 1'b1 && prev[0] === 1'b0) cnt2++;
         if (ref_out[3] === 1'b1 && prev[1] === 1'b0) cnt3++;
         prev = ref_out[3:2];
      end
      chk(16'(cnt2), 16'd4);
      chk(16'(cnt3), 16'd8);
      $display("Test input done");
      end_sim();
   end
endmodule
